// ### core/fcg_top.sv
// Flash configuration guard: timing ratio, security, protection maps.
`timescale 1ns/100ps
`include "fcg_regs.svh"
module fcg_top (
  // Clock, reset and enable
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  // Configuration field longwords read from the array at reset
  input wire logic [31:0] i_fld_block_guard_bits,
  input wire logic [31:0] i_fld_sacc,
  input wire logic [31:0] i_fld_sec,
  // Peripheral register bus
  input wire logic i_bus_req,
  input wire logic i_bus_we,
  input wire logic [5:0] i_bus_addr,
  input wire logic [3:0] i_bus_be,
  input wire logic [31:0] i_bus_wdata,
  input wire logic i_bus_super,
  output logic o_bus_ack,
  output logic o_bus_err,
  output logic [31:0] o_bus_rdata,
  // Array access checks
  input wire logic i_arr_req,
  input wire logic i_arr_we,
  input wire logic [18:0] i_arr_addr,
  input wire logic i_arr_super,
  output logic o_arr_ack,
  output logic o_arr_err,
  output logic o_arr_key_write,
  output logic o_pe_launch,
  output logic o_pe_violation,
  // Timing and chip-level security
  input wire logic i_ext_single_chip,
  output logic o_timing_tick,
  output logic o_debug_block,
  output logic o_single_chip,
  output logic o_backdoor_enable
);
  fcg_div_if dif ();

  // ============================================================
  // State
  logic cfg_lock;
  logic cfg_key_write_mode;
  logic [3:0] cfg_ie;
  logic ratio_loaded_flag;
  logic prescale_by_eight;
  fcg_pkg::fcg_ratio_t ratio;
  logic backdoor_key_enable;
  logic guard_active_flag;
  logic [13:0] sec_rsvd;
  logic [15:0] guard_word;
  fcg_pkg::fcg_word_t erase_guard_mask;
  fcg_pkg::fcg_word_t privilege_block_map;
  logic ext_meta;
  logic ext_sync;

  // ============================================================
  // Bus decode
  wire bus_ok = i_bus_req && i_bus_super;
  wire bus_wr = bus_ok && i_bus_we;
  wire hit_cfg = i_bus_addr == `FCG_OFS_CFG;
  wire hit_sec = i_bus_addr == `FCG_OFS_SEC;
  wire hit_block_guard_bits = i_bus_addr == `FCG_OFS_BLOCK_GUARD_BITS;
  wire hit_sacc = i_bus_addr == `FCG_OFS_SACC;
  wire wr_cfg_hi = bus_wr && hit_cfg && i_bus_be[3];
  wire wr_cfg_lo = bus_wr && hit_cfg && i_bus_be[2];
  wire wr_clk = bus_wr && hit_cfg && i_bus_be[1];
  wire maps_open = !cfg_lock;
  wire [31:0] be_mask = {{8{i_bus_be[3]}}, {8{i_bus_be[2]}},
                         {8{i_bus_be[1]}}, {8{i_bus_be[0]}}};
  wire [31:0] next_block_guard_bits = (erase_guard_mask & ~be_mask)
                          | (i_bus_wdata & be_mask);
  wire [31:0] next_sacc = (privilege_block_map & ~be_mask)
                          | (i_bus_wdata & be_mask);
  wire [31:0] rd_cfg = {5'h00, cfg_lock, cfg_ie, cfg_key_write_mode, 5'h00,
                        ratio_loaded_flag, prescale_by_eight, ratio,
                        8'h00};
  wire [31:0] rd_sec = {backdoor_key_enable, guard_active_flag,
                        sec_rsvd, guard_word};
  // Unmapped offsets read as zero and take no write.
  wire [31:0] next_rdata = hit_cfg ? rd_cfg
                         : hit_sec ? rd_sec
                         : hit_block_guard_bits ? erase_guard_mask
                         : hit_sacc ? privilege_block_map
                         : 32'h0000_0000;

  // ============================================================
  // Array decode
  // block index
  wire fcg_pkg::fcg_blk_t blk = i_arr_addr[`FCG_BLK_MSB:`FCG_BLK_LSB];
  wire user_denied = privilege_block_map[blk] && !i_arr_super;
  wire fcg_pkg::fcg_arr_kind_t kind = !i_arr_we ? fcg_pkg::FCG_ARR_READ
                                    : cfg_key_write_mode ? fcg_pkg::FCG_ARR_KEY
                                    : fcg_pkg::FCG_ARR_CMD;
  wire blk_guarded = erase_guard_mask[blk];
  wire arr_take = i_arr_req && !user_denied;
  wire cmd_take = arr_take && kind == fcg_pkg::FCG_ARR_CMD;

  // ============================================================
  // Reset load and register writes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cfg_lock <= 1'b0;
      cfg_key_write_mode <= 1'b0;
      cfg_ie <= 4'h0;
      ratio_loaded_flag <= 1'b0;
      prescale_by_eight <= 1'b0;
      ratio <= `FCG_RATIO_RST;
      backdoor_key_enable <= i_fld_sec[`FCG_SEC_BACKDOOR_KEY_ENABLE];
      sec_rsvd <= i_fld_sec[`FCG_SEC_RSVD_MSB:`FCG_SEC_RSVD_LSB];
      guard_word <= i_fld_sec[`FCG_SEC_WORD_MSB:`FCG_SEC_WORD_LSB];
      guard_active_flag <= i_fld_sec[`FCG_SEC_WORD_MSB:`FCG_SEC_WORD_LSB]
                           == `FCG_SEC_MAGIC;
      erase_guard_mask <= i_fld_block_guard_bits;
      privilege_block_map <= i_fld_sacc;
    end
    else if (i_ce)
    begin
      if (wr_cfg_hi && i_bus_wdata[`FCG_CFG_LOCK])
        cfg_lock <= 1'b1;
      if (wr_cfg_hi)
        cfg_ie[3:2] <= i_bus_wdata[`FCG_CFG_IE_MSB -: 2];
      if (wr_cfg_lo)
        cfg_ie[1:0] <= i_bus_wdata[`FCG_CFG_IE_LSB +: 2];
      if (wr_cfg_lo && backdoor_key_enable)
        cfg_key_write_mode <= i_bus_wdata[`FCG_CFG_KEY_WRITE_MODE];
      if (wr_clk && !ratio_loaded_flag)
      begin
        prescale_by_eight <= i_bus_wdata[`FCG_CLK_PRESCALE];
        ratio <= i_bus_wdata[`FCG_CLK_RATIO_MSB:`FCG_CLK_RATIO_LSB];
      end
      if (wr_clk)
        ratio_loaded_flag <= 1'b1;
      if (bus_wr && hit_block_guard_bits && maps_open)
        erase_guard_mask <= next_block_guard_bits;
      if (bus_wr && hit_sacc && maps_open)
        privilege_block_map <= next_sacc;
    end
  end

  // ============================================================
  // Bus answer, one cycle after the request
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_bus_ack <= 1'b0;
      o_bus_err <= 1'b0;
      o_bus_rdata <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      o_bus_ack <= i_bus_req;
      // Supervisor-only window: user cycles end in a transfer error.
      o_bus_err <= i_bus_req && !i_bus_super;
      o_bus_rdata <= (bus_ok && !i_bus_we) ? next_rdata : 32'h0000_0000;
    end
  end

  // ============================================================
  // Array answer, one cycle after the request
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_arr_ack <= 1'b0;
      o_arr_err <= 1'b0;
      o_arr_key_write <= 1'b0;
      o_pe_launch <= 1'b0;
      o_pe_violation <= 1'b0;
    end
    else if (i_ce)
    begin
      o_arr_ack <= i_arr_req;
      o_arr_err <= i_arr_req && user_denied;
      o_arr_key_write <= arr_take && kind == fcg_pkg::FCG_ARR_KEY;
      o_pe_launch <= cmd_take && !blk_guarded;
      o_pe_violation <= cmd_take && blk_guarded;
    end
  end

  // ============================================================
  // Chip-level security effects
  // The strap pin is asynchronous, so it passes two flops first.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else if (i_ce)
    begin
      ext_meta <= i_ext_single_chip;
      ext_sync <= ext_meta;
    end
  end

  assign o_debug_block = guard_active_flag;
  assign o_single_chip = guard_active_flag || ext_sync;
  assign o_backdoor_enable = backdoor_key_enable;

  // ============================================================
  // Timing divider
  assign dif.loaded = ratio_loaded_flag;
  assign dif.prescale = prescale_by_eight;
  assign dif.ratio = ratio;
  assign o_timing_tick = dif.tick;

  fcg_tdiv u_tdiv (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .div(dif.div)
  );

  // ============================================================
  // Checks
  a_loaded_flag_set: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && wr_clk) |=> ratio_loaded_flag)
    else $error("ratio write did not set loaded flag");

  a_ratio_write_once: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && wr_clk && ratio_loaded_flag) |=> $stable(ratio)
      && $stable(prescale_by_eight))
    else $error("ratio changed on a second write");

  a_tick_spacing: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && o_timing_tick && !prescale_by_eight && ratio == 6'h02)
      ##1 i_ce [*2] |=> o_timing_tick && !$past(o_timing_tick)
      && !$past(o_timing_tick, 2))
    else $error("ratio divider period wrong");

  a_backdoor_out: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    $past(i_srst) |-> o_backdoor_enable
      == $past(i_fld_sec[`FCG_SEC_BACKDOOR_KEY_ENABLE]))
    else $error("backdoor output differs from loaded longword");

  a_secure_debug: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (guard_word == `FCG_SEC_MAGIC) |-> o_debug_block && o_single_chip)
    else $error("secured part left debug or boot open");

  a_mask_frozen: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (cfg_lock && i_ce) |=> $stable(erase_guard_mask))
    else $error("frozen mask changed");

  a_map_frozen: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (cfg_lock && i_ce) |=> $stable(privilege_block_map))
    else $error("frozen privilege map changed");

  a_user_denied: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && i_arr_req && !i_arr_super
      && privilege_block_map[blk]) |=> o_arr_err && !o_pe_launch)
    else $error("user access to privileged block not refused");

  a_freeze_sticky: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    cfg_lock |=> cfg_lock)
    else $error("freeze bit cleared without reset");

  a_key_write_mode_gate: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && !backdoor_key_enable) |=> $stable(cfg_key_write_mode))
    else $error("key mode changed with key path disabled");

  a_silent_ignore: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && bus_wr && hit_block_guard_bits && cfg_lock) |=> o_bus_ack && !o_bus_err)
    else $error("frozen write did not complete normally");

  a_guard_launch: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && cmd_take && blk_guarded) |=> o_pe_violation && !o_pe_launch)
    else $error("guarded block command launched");

  a_guard_status: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    $past(i_srst) |-> guard_active_flag
      == ($past(i_fld_sec[`FCG_SEC_WORD_MSB:`FCG_SEC_WORD_LSB])
      == `FCG_SEC_MAGIC))
    else $error("security status disagrees with guard word");

  a_status_steady: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    !$past(i_srst) |-> $stable(guard_active_flag))
    else $error("security status changed outside reset");

  a_guard_load: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    $past(i_srst) |-> rd_sec[`FCG_SEC_RSVD_MSB:`FCG_SEC_WORD_LSB]
      == $past(i_fld_sec[`FCG_SEC_RSVD_MSB:`FCG_SEC_WORD_LSB]))
    else $error("guard register not loaded from security longword");

  a_mask_load: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    $past(i_srst) |-> erase_guard_mask == $past(i_fld_block_guard_bits))
    else $error("mask not loaded from protection longword");

  a_map_load: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    $past(i_srst) |-> privilege_block_map == $past(i_fld_sacc))
    else $error("privilege map not loaded from its longword");

  a_launch_open: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && cmd_take && !blk_guarded) |=> o_pe_launch && !o_pe_violation)
    else $error("command to open block not launched");

  a_user_allowed: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && i_arr_req && !i_arr_super
      && !privilege_block_map[blk]) |=> !o_arr_err)
    else $error("user access to open block refused");

  a_ratio_first: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && wr_clk && !ratio_loaded_flag) |=> ratio
      == $past(i_bus_wdata[`FCG_CLK_RATIO_MSB:`FCG_CLK_RATIO_LSB]))
    else $error("first ratio write not taken");

  a_bus_answer: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && i_bus_req && i_bus_super) |=> o_bus_ack && !o_bus_err)
    else $error("supervisor cycle not answered cleanly");
endmodule

// ### core/fcg_regs.svh
// Register offsets, field positions, reset values and timing figures.
// Behaviour
// - Ratio bit 7 shows written since reset.
// - Ratio low seven bits take first write.
// - Prescale bit divides module clock by eight.
// - Six-bit ratio divides after optional prescale.
// - Guard bit 31 enables backdoor key path.
// - Guard bit 30 reports security active.
// - Guard bits load from longword 0x414.
// - Secured only when guard word 0x4AC8.
// - Security blocks background debug port.
// - Security forces single-chip boot mode.
// - Mask bit set forbids block program/erase.
// - Mask writable only while freeze clear.
// - Mask loads from longword 0x400.
// - Thirty-two 16K blocks; small arrays use sixteen; the code always decodes thirty-two.
// - Privilege map writable only while freeze clear.
// - Privileged block: user access gets transfer error.
// - Privilege map loads from longword 0x40C.
// - Freeze bit 10 sets once, locks maps.
// - Key mode writable only with key enable.
`ifndef FCG_REGS_SVH
`define FCG_REGS_SVH

// ============================================================
// Register byte offsets within the flash module window
`define FCG_OFS_CFG 6'h00
`define FCG_OFS_SEC 6'h08
`define FCG_OFS_BLOCK_GUARD_BITS 6'h10
`define FCG_OFS_SACC 6'h14

// ============================================================
// Field positions in the 32-bit bus words and the block index in the array address
`define FCG_CFG_LOCK 26
`define FCG_CFG_IE_MSB 25
`define FCG_CFG_IE_LSB 22
`define FCG_CFG_KEY_WRITE_MODE 21
`define FCG_CLK_LOADED 15
`define FCG_CLK_PRESCALE 14
`define FCG_CLK_RATIO_MSB 13
`define FCG_CLK_RATIO_LSB 8
`define FCG_SEC_BACKDOOR_KEY_ENABLE 31
`define FCG_SEC_ACTIVE 30
`define FCG_SEC_RSVD_MSB 29
`define FCG_SEC_RSVD_LSB 16
`define FCG_SEC_WORD_MSB 15
`define FCG_SEC_WORD_LSB 0
`define FCG_BLK_MSB 18
`define FCG_BLK_LSB 14

// ============================================================
// Values and configuration field locations
`define FCG_SEC_MAGIC 16'h4ac8
`define FCG_FLD_BLOCK_GUARD_BITS 32'h0000_0400
`define FCG_FLD_SACC 32'h0000_040c
`define FCG_FLD_SEC 32'h0000_0414
`define FCG_RATIO_RST 6'h00

// ============================================================
// Timing figures
`define FCG_PRESCALE_DIV 4'h8
`define FCG_PRESCALE_LAST 3'h7
`define FCG_TCLK_MIN_KHZ 150
`define FCG_TCLK_MAX_KHZ 200
`define FCG_MCLK_MAX_KHZ 102400

`endif

// ### core/fcg_pkg.sv
// Types shared by the flash configuration guard modules.
package fcg_pkg;
  typedef logic [31:0] fcg_word_t;
  typedef logic [4:0] fcg_blk_t;
  typedef logic [5:0] fcg_ratio_t;
  typedef enum logic [1:0] {
    FCG_ARR_READ,
    FCG_ARR_KEY,
    FCG_ARR_CMD
  } fcg_arr_kind_t;
endpackage

// ### core/fcg_div_if.sv
// Carrier between the register block and the timing divider.
`timescale 1ns/100ps
interface fcg_div_if;
  logic loaded;
  logic prescale;
  fcg_pkg::fcg_ratio_t ratio;
  logic tick;
  modport regs (output loaded, output prescale, output ratio, input tick);
  modport div (input loaded, input prescale, input ratio, output tick);
endinterface

// ### core/fcg_tdiv.sv
// Timing clock divider: optional divide by eight, then divide by ratio plus one.
`timescale 1ns/100ps
`include "fcg_regs.svh"
module fcg_tdiv (
  // Clock, reset and enable
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  // Settings from the register block
  fcg_div_if.div div
);
  logic [2:0] pre_cnt;
  fcg_pkg::fcg_ratio_t div_cnt;
  logic tick;
  wire pre_en;
  wire div_wrap;

  // ============================================================
  // Prescaler
  // prescale by eight
  assign pre_en = !div.prescale || (pre_cnt == `FCG_PRESCALE_LAST);
  assign div_wrap = pre_en && (div_cnt == div.ratio);
  assign div.tick = tick;

  // Nothing counts until software has loaded a ratio.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || !div.loaded)
    begin
      pre_cnt <= 3'h0;
      div_cnt <= 6'h00;
      tick <= 1'b0;
    end
    else if (i_ce)
    begin
      pre_cnt <= div.prescale ? pre_cnt + 3'h1 : 3'h0;
      if (pre_en)
        div_cnt <= div_wrap ? 6'h00 : div_cnt + 6'h01;
      tick <= div_wrap;
    end
  end

  a_prescale_gap: assert property (@(posedge i_clk_sys)
    disable iff (i_srst)
    (i_ce && div.loaded && div.prescale && pre_cnt == 3'h0
     && $stable(div.prescale)) |=> !pre_en)
    else $error("prescaler passed an edge before its eighth cycle");
endmodule

// ### tb/fcg_core_model.sv
// Processor core model issuing register cycles toward the guard block.
`timescale 1ns/100ps
module fcg_core_model (
  // Clock
  input wire logic i_clk_sys,
  // Register bus toward the device
  output logic o_bus_req,
  output logic o_bus_we,
  output logic [5:0] o_bus_addr,
  output logic [3:0] o_bus_be,
  output logic [31:0] o_bus_wdata,
  output logic o_bus_super,
  input wire logic i_bus_ack,
  input wire logic i_bus_err,
  input wire logic [31:0] i_bus_rdata
);
  initial
  begin
    o_bus_req = 1'b0;
    o_bus_we = 1'b0;
    o_bus_addr = 6'h00;
    o_bus_be = 4'h0;
    o_bus_wdata = 32'h0000_0000;
    o_bus_super = 1'b1;
  end

  // The request lasts one cycle; the answer is taken mid-way through the
  // next one. Released data is inverted so a stale value cannot pass.
  task automatic access(input logic we, input logic [5:0] addr,
    input logic [3:0] be, input logic [31:0] wdata, input logic sup,
    output logic [31:0] rdata, output logic err, output logic ack);
    @(negedge i_clk_sys);
    o_bus_req = 1'b1;
    o_bus_we = we;
    o_bus_addr = addr;
    o_bus_be = be;
    o_bus_wdata = wdata;
    o_bus_super = sup;
    @(negedge i_clk_sys);
    ack = i_bus_ack;
    err = i_bus_err;
    rdata = i_bus_rdata;
    o_bus_req = 1'b0;
    o_bus_we = 1'b0;
    o_bus_wdata = ~wdata;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the flash configuration guard block.
`timescale 1ns/100ps
module testbench;
  logic i_clk_sys, i_srst, i_ce, strap;
  logic [31:0] fld_block_guard_bits, fld_sacc, fld_sec;
  logic bus_req, bus_we, bus_super, bus_ack, bus_err, ack, err;
  logic [5:0] bus_addr;
  logic [3:0] bus_be;
  logic [31:0] bus_wdata, bus_rdata, rd;
  logic arr_req, arr_we, arr_super, arr_ack, arr_err;
  logic key_wr, launch, viol, tick, dbg, single, bkd;
  logic [18:0] arr_addr;
  int errors, tests_run, cycles;

  fcg_core_model i_fcg_core_model (
    .i_clk_sys(i_clk_sys), .o_bus_req(bus_req), .o_bus_we(bus_we),
    .o_bus_addr(bus_addr), .o_bus_be(bus_be), .o_bus_wdata(bus_wdata),
    .o_bus_super(bus_super), .i_bus_ack(bus_ack), .i_bus_err(bus_err),
    .i_bus_rdata(bus_rdata)
  );

  fcg_top i_fcg_top (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce),
    .i_fld_block_guard_bits(fld_block_guard_bits), .i_fld_sacc(fld_sacc), .i_fld_sec(fld_sec),
    .i_bus_req(bus_req), .i_bus_we(bus_we), .i_bus_addr(bus_addr),
    .i_bus_be(bus_be), .i_bus_wdata(bus_wdata), .i_bus_super(bus_super),
    .o_bus_ack(bus_ack), .o_bus_err(bus_err), .o_bus_rdata(bus_rdata),
    .i_arr_req(arr_req), .i_arr_we(arr_we), .i_arr_addr(arr_addr),
    .i_arr_super(arr_super), .o_arr_ack(arr_ack), .o_arr_err(arr_err),
    .o_arr_key_write(key_wr), .o_pe_launch(launch),
    .o_pe_violation(viol), .i_ext_single_chip(strap),
    .o_timing_tick(tick), .o_debug_block(dbg), .o_single_chip(single),
    .o_backdoor_enable(bkd)
  );

  // ============================================================
  // Clock, timeout and shared tasks
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [31:0] sec);
    @(negedge i_clk_sys);
    i_srst = 1'b1;
    fld_sec = sec;
    repeat (20) @(negedge i_clk_sys);
    i_srst = 1'b0;
  endtask

  task automatic rw(input logic we, input logic [5:0] a,
    input logic [3:0] be, input logic [31:0] d, input logic su,
    input logic e);
    i_fcg_core_model.access(we, a, be, d, su, rd, err, ack);
    chk(32'({ack, err}), 32'({1'b1, e}));
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    rw(1'b0, a, 4'hf, 32'h0000_0000, 1'b1, 1'b0);
    chk(rd, exp);
  endtask

  // Expected is {err, key write, launch, violation}, always with an ack.
  task automatic arr(input logic we, input logic [18:0] a,
    input logic su, input logic [3:0] exp);
    @(negedge i_clk_sys);
    arr_req = 1'b1;
    arr_we = we;
    arr_addr = a;
    arr_super = su;
    @(negedge i_clk_sys);
    arr_req = 1'b0;
    chk(32'({arr_ack, arr_err, key_wr, launch, viol}), 32'({1'b1, exp}));
  endtask

  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 300)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge i_clk_sys);
      n++;
    end while (tick !== 1'b1 && n < 300);
    chk(32'(n), 32'(exp));
  endtask

  // ============================================================
  // Scenarios
  task automatic t_boot();
    rd_chk(6'h10, 32'h0000_0008);
    rd_chk(6'h14, 32'h0000_0020);
    rd_chk(6'h08, 32'hc012_4ac8);
    rd_chk(6'h00, 32'h0000_0000);
    rd_chk(6'h04, 32'h0000_0000);
    chk(32'({dbg, single, bkd}), 32'h7);
  endtask

  task automatic t_ratio();
    rw(1'b1, 6'h00, 4'h2, 32'h0000_0200, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0000_8200);
    tick_gap(3);
    rw(1'b1, 6'h00, 4'h2, 32'h0000_7f00, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0000_8200);
    rw(1'b1, 6'h08, 4'hf, 32'hffff_ffff, 1'b1, 1'b0);
    rd_chk(6'h08, 32'hc012_4ac8);
  endtask

  task automatic t_guard();
    rw(1'b0, 6'h10, 4'hf, 32'h0000_0000, 1'b0, 1'b1);
    arr(1'b1, 19'h0c000, 1'b1, 4'h1);
    arr(1'b1, 19'h10000, 1'b1, 4'h2);
    arr(1'b0, 19'h14000, 1'b0, 4'h8);
    arr(1'b0, 19'h14000, 1'b1, 4'h0);
    arr(1'b0, 19'h10000, 1'b0, 4'h0);
    rw(1'b1, 6'h10, 4'hf, 32'h0000_0000, 1'b1, 1'b0);
    arr(1'b1, 19'h0c000, 1'b1, 4'h2);
    rw(1'b1, 6'h14, 4'hf, 32'hffff_0000, 1'b1, 1'b0);
    rd_chk(6'h14, 32'hffff_0000);
    rw(1'b1, 6'h00, 4'h4, 32'h0020_0000, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0020_8200);
    arr(1'b1, 19'h10000, 1'b1, 4'h4);
    rw(1'b1, 6'h00, 4'h8, 32'h0400_0000, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0420_8200);
    rw(1'b1, 6'h10, 4'hf, 32'hffff_ffff, 1'b1, 1'b0);
    rd_chk(6'h10, 32'h0000_0000);
    rw(1'b1, 6'h14, 4'hf, 32'h0000_0000, 1'b1, 1'b0);
    rd_chk(6'h14, 32'hffff_0000);
    rw(1'b1, 6'h00, 4'h8, 32'h0000_0000, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0420_8200);
  endtask

  // A guard word one off the secure value must leave the part open.
  task automatic t_open();
    fld_block_guard_bits = 32'h8000_0008;
    do_reset(32'h0000_4ac9);
    rd_chk(6'h10, 32'h8000_0008);
    rd_chk(6'h08, 32'h0000_4ac9);
    chk(32'({dbg, single, bkd}), 32'h0);
    strap = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk(32'(single), 32'h1);
    rw(1'b1, 6'h00, 4'h4, 32'h0020_0000, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0000_0000);
    rw(1'b1, 6'h00, 4'h2, 32'h0000_4100, 1'b1, 1'b0);
    rd_chk(6'h00, 32'h0000_c100);
    tick_gap(16);
    arr(1'b1, 19'h0c000, 1'b1, 4'h1);
    arr(1'b1, 19'h7c000, 1'b1, 4'h1);
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    i_srst = 1'b1;
    i_ce = 1'b1;
    strap = 1'b0;
    fld_block_guard_bits = 32'h0000_0008;
    fld_sacc = 32'h0000_0020;
    fld_sec = 32'h8012_4ac8;
    arr_req = 1'b0;
    arr_we = 1'b0;
    arr_addr = 19'h00000;
    arr_super = 1'b1;
    do_reset(32'h8012_4ac8);
    t_boot();
    t_ratio();
    t_guard();
    t_open();
    test_done();
  end
endmodule
